/* hw/ctc_clk_div.sv */
module ctc_clk_div (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic src_clk,
	input wire logic [6:0] ratio_m1,
	output logic clk_out
);
	import ctc_pkg::*;

	typedef struct packed {
		logic prev;
		logic [6:0] cnt;
		logic [6:0] ratio;
		logic out;
	} ctc_div_state_t;

	ctc_div_state_t s_q;
	ctc_div_state_t s_d;

	// ----------------------------------------
	// divide by ratio_m1 + 1, new ratio taken at wrap only
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.prev = src_clk;
		if (src_clk && !s_q.prev) begin
			if (s_q.cnt >= s_q.ratio) begin
				s_d.cnt = 7'h00;
				s_d.ratio = ratio_m1;
			end else begin
				s_d.cnt = s_q.cnt + 7'h01;
			end
		end
		if (s_d.ratio == 7'h00) begin
			s_d.out = src_clk;
		end else begin
			s_d.out = (s_d.cnt <= (s_d.ratio >> 1));
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign clk_out = s_q.out;

endmodule : ctc_clk_div

/* hw/ctc_clock_tree.sv */
import ctc_pkg::*;

module ctc_clock_tree (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic ring_oscillator,
	input wire logic trim_rc_osc,
	input wire logic crystal_osc,
	input wire logic ext_clock_in,
	input wire logic pll_out_clock,
	output logic [1:0] ring_osc_freq,
	output logic pll_enable,
	output logic free_running_clock,
	output logic fast_clock,
	output logic power_mgr_clock,
	output logic high_speed_clock,
	output logic aux_clock,
	output logic adc_clock,
	output logic core_clock,
	output logic memory_clock,
	output logic serial_clock,
	output logic timer_clock
);
	import ctc_pkg::*;

	typedef struct packed {
		logic [CTC_NUM_PINS-1:0] s1;
		logic [CTC_NUM_PINS-1:0] s2;
		logic [CTC_NUM_PINS-1:0] s3;
		logic [CTC_NUM_PINS-1:0] filt;
		logic [1:0] src_sel;
		logic fast_pll;
		logic [1:0] freq;
		logic pll_en;
		logic [1:0] hs_div;
		logic [6:0] aux_m1;
		logic deep_sleep;
		ctc_sw_t frc_st;
		logic [1:0] frc_active;
		logic frc;
		ctc_sw_t fast_st;
		logic fast_active;
		logic fast;
		logic pm;
		logic sleep_fast;
		logic sleep_hs;
		logic sleep_aux;
		logic adc;
		logic core;
		logic mem;
		logic ser;
		logic tmr;
		logic [2:0] meas_prev;
		logic [2:0][9:0] meas_cnt;
		logic [9:0] win;
		logic ref_ok;
		logic hs_over;
		logic aux_over;
		logic [31:0] rdata;
	} ctc_state_t;

	ctc_state_t s_q;
	ctc_state_t s_d;
	logic [CTC_NUM_PINS-1:0] filt_nxt;
	logic hs_out;
	logic aux_out;
	logic frc_old_lvl;
	logic frc_new_lvl;
	logic fast_old_lvl;
	logic fast_new_lvl;
	logic [2:0] meas_lvl;
	logic win_end;

	// ----------------------------------------
	// pin filters: change taken when stages two and three agree
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < CTC_NUM_PINS; gi++) begin : g_filt
			assign filt_nxt[gi] = (s_q.s2[gi] == s_q.s3[gi]) ? s_q.s3[gi] : s_q.filt[gi];
		end
	endgenerate

	// ----------------------------------------
	// dividers
	// ----------------------------------------
	ctc_clk_div u_hs_div (
		.core_clk(core_clk),
		.reset(reset),
		.src_clk(s_q.fast),
		.ratio_m1(7'((8'h01 << s_q.hs_div) - 8'h01)),
		.clk_out(hs_out)
	);

	ctc_clk_div u_aux_div (
		.core_clk(core_clk),
		.reset(reset),
		.src_clk(s_q.fast),
		.ratio_m1(s_q.aux_m1),
		.clk_out(aux_out)
	);

	// four sources only, no slow oscillator input
	assign frc_old_lvl = s_q.filt[s_q.frc_active];
	assign frc_new_lvl = s_q.filt[s_q.src_sel];
	assign fast_old_lvl = s_q.fast_active ? s_q.filt[CTC_PIN_PLL] : s_q.frc;
	assign fast_new_lvl = s_q.fast_pll ? s_q.filt[CTC_PIN_PLL] : s_q.frc;
	assign meas_lvl = {aux_out, hs_out, s_q.frc};
	assign win_end = (s_q.win == CTC_WINDOW_CYC);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.s1 = {pll_out_clock, ext_clock_in, crystal_osc, trim_rc_osc, ring_oscillator};
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		s_d.filt = filt_nxt;

		// register writes
		if (reg_write) begin
			case (reg_addr)
				CTC_ADDR_CTRL: begin
					s_d.src_sel = reg_wdata[CTC_CTRL_SRC_LSB +: 2];
					s_d.fast_pll = reg_wdata[CTC_CTRL_FAST_PLL_BIT];
					s_d.freq = reg_wdata[CTC_CTRL_FREQ_LSB +: 2];
					s_d.pll_en = reg_wdata[CTC_CTRL_PLL_EN_BIT];
				end
				CTC_ADDR_DIV: begin
					s_d.hs_div = reg_wdata[CTC_DIV_HS_LSB +: 2];
					s_d.aux_m1 = reg_wdata[CTC_DIV_AUX_LSB +: 7];
				end
				CTC_ADDR_SLEEP: begin
					s_d.deep_sleep = reg_wdata[CTC_SLEEP_DEEP_BIT];
				end
				default: begin
				end
			endcase
		end

		// register reads, data valid for one cycle only
		s_d.rdata = 32'h0000_0000;
		if (reg_read) begin
			case (reg_addr)
				CTC_ADDR_CTRL: begin
					s_d.rdata = 32'({s_q.pll_en, s_q.freq, s_q.fast_pll, s_q.src_sel});
				end
				CTC_ADDR_DIV: begin
					s_d.rdata = 32'({s_q.aux_m1, 6'h00, s_q.hs_div});
				end
				CTC_ADDR_SLEEP: begin
					s_d.rdata = 32'(s_q.deep_sleep);
				end
				CTC_ADDR_STATUS: begin
					s_d.rdata = 32'({s_q.aux_over, s_q.hs_over, s_q.ref_ok,
						(s_q.frc_st != CTC_SW_RUN) || (s_q.fast_st != CTC_SW_RUN),
						s_q.fast_active, s_q.frc_active});
				end
				default: begin
				end
			endcase
		end

		// free-running source switch: old low, hold low, new low
		case (s_q.frc_st)
			CTC_SW_RUN: begin
				s_d.frc = frc_old_lvl;
				if (s_q.src_sel != s_q.frc_active) begin
					s_d.frc_st = CTC_SW_WAIT_LOW;
				end
			end
			CTC_SW_WAIT_LOW: begin
				s_d.frc = frc_old_lvl;
				if (!frc_old_lvl && !s_q.frc) begin
					s_d.frc = 1'b0;
					s_d.frc_st = CTC_SW_HOLD;
				end
			end
			CTC_SW_HOLD: begin
				s_d.frc = 1'b0;
				if (!frc_new_lvl) begin
					s_d.frc_active = s_q.src_sel;
					s_d.frc_st = CTC_SW_RUN;
				end
			end
			default: begin
				s_d.frc = 1'b0;
				s_d.frc_st = CTC_SW_RUN;
			end
		endcase

		// fast clock selector, same switch sequence
		case (s_q.fast_st)
			CTC_SW_RUN: begin
				s_d.fast = fast_old_lvl;
				if (s_q.fast_pll != s_q.fast_active) begin
					s_d.fast_st = CTC_SW_WAIT_LOW;
				end
			end
			CTC_SW_WAIT_LOW: begin
				s_d.fast = fast_old_lvl;
				if (!fast_old_lvl && !s_q.fast) begin
					s_d.fast = 1'b0;
					s_d.fast_st = CTC_SW_HOLD;
				end
			end
			CTC_SW_HOLD: begin
				s_d.fast = 1'b0;
				if (!fast_new_lvl) begin
					s_d.fast_active = s_q.fast_pll;
					s_d.fast_st = CTC_SW_RUN;
				end
			end
			default: begin
				s_d.fast = 1'b0;
				s_d.fast_st = CTC_SW_RUN;
			end
		endcase

		// power manager clock from trimmed oscillator always
		s_d.pm = s_q.filt[CTC_SRC_TRIM];

		// deep-sleep gates, enables move only while the clock is low
		if (!s_q.fast) begin
			s_d.sleep_fast = s_q.deep_sleep;
		end
		if (!hs_out) begin
			s_d.sleep_hs = s_q.deep_sleep;
		end
		if (!aux_out) begin
			s_d.sleep_aux = s_q.deep_sleep;
		end
		s_d.adc = s_q.fast & !s_q.sleep_fast;
		s_d.core = hs_out & !s_q.sleep_hs;
		s_d.mem = hs_out & !s_q.sleep_hs;
		s_d.ser = hs_out & !s_q.sleep_hs;
		s_d.tmr = aux_out & !s_q.sleep_aux;

		// rate monitor: rising edges per window
		s_d.meas_prev = meas_lvl;
		for (int i = 0; i < 3; i++) begin
			if (win_end) begin
				s_d.meas_cnt[i] = 10'h000;
			end else if (meas_lvl[i] && !s_q.meas_prev[i] && s_q.meas_cnt[i] != 10'h3FF) begin
				s_d.meas_cnt[i] = s_q.meas_cnt[i] + 10'h001;
			end
		end
		if (win_end) begin
			s_d.win = 10'h000;
			s_d.ref_ok = (s_q.meas_cnt[0] >= CTC_REF_MIN_CNT) && (s_q.meas_cnt[0] <= CTC_REF_MAX_CNT);
			s_d.hs_over = s_q.meas_cnt[1] > CTC_HS_MAX_CNT;
			s_d.aux_over = s_q.meas_cnt[2] > CTC_AUX_MAX_CNT;
		end else begin
			s_d.win = s_q.win + 10'h001;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
			s_q.src_sel <= CTC_RST_SRC;
			s_q.frc_active <= CTC_RST_SRC;
			s_q.freq <= CTC_RST_FREQ;
			s_q.hs_div <= CTC_RST_HS_DIV;
			s_q.aux_m1 <= CTC_RST_AUX_M1;
			s_q.frc_st <= CTC_SW_RUN;
			s_q.fast_st <= CTC_SW_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = s_q.rdata;
	assign ring_osc_freq = s_q.freq;
	assign pll_enable = s_q.pll_en;
	assign free_running_clock = s_q.frc;
	assign fast_clock = s_q.fast;
	assign power_mgr_clock = s_q.pm;
	assign high_speed_clock = hs_out;
	assign aux_clock = aux_out;
	assign adc_clock = s_q.adc;
	assign core_clock = s_q.core;
	assign memory_clock = s_q.mem;
	assign serial_clock = s_q.ser;
	assign timer_clock = s_q.tmr;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	logic first_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	a_reset_ring_low: assert property (first_q |-> s_q.frc_active == CTC_SRC_RING && ring_osc_freq == 2'h3)
		else $error("reset did not pick ring oscillator at lowest setting");
	a_freq_field_write: assert property (reg_write && reg_addr == CTC_ADDR_CTRL
		|=> ring_osc_freq == $past(reg_wdata[4:3]))
		else $error("ring frequency field not applied");
	a_frc_follows_src: assert property (s_q.frc_st == CTC_SW_RUN |=> free_running_clock == $past(frc_old_lvl))
		else $error("free clock not from active source");
	a_frc_hold_low: assert property (s_q.frc_st == CTC_SW_HOLD |=> !free_running_clock)
		else $error("free clock high during switch");
	a_fast_direct: assert property (s_q.fast_st == CTC_SW_RUN && !s_q.fast_active
		|=> fast_clock == $past(free_running_clock))
		else $error("fast clock not passing free clock");
	a_ref_range: assert property (win_end |=> s_q.ref_ok == ($past(s_q.meas_cnt[0]) >= 10'h004
		&& $past(s_q.meas_cnt[0]) <= 10'h064))
		else $error("reference range flag wrong");
	a_sleep_core_off: assert property (s_q.sleep_hs [*2] |-> !core_clock && !memory_clock && !serial_clock)
		else $error("core clock runs in deep sleep");
	a_sleep_moves_low: assert property ($changed(s_q.sleep_hs) |-> !$past(hs_out))
		else $error("gate enable moved while clock high");
	a_trim_to_pm: assert property (##1 power_mgr_clock == $past(s_q.filt[1]))
		else $error("power manager clock not from trimmed oscillator");

	c_src_switch: cover property (s_q.frc_st == CTC_SW_HOLD ##1 s_q.frc_st == CTC_SW_RUN);
	c_fast_to_pll: cover property (s_q.fast_st == CTC_SW_HOLD ##1 s_q.fast_active);
	c_deep_sleep: cover property ($rose(s_q.sleep_hs));
	c_window_end: cover property (win_end && s_q.ref_ok);

endmodule : ctc_clock_tree

/* hw/ctc_pkg.sv */
package ctc_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] CTC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] CTC_ADDR_DIV = 8'h04;
	localparam logic [7:0] CTC_ADDR_SLEEP = 8'h08;
	localparam logic [7:0] CTC_ADDR_STATUS = 8'h0C;

	// control fields
	localparam int CTC_CTRL_SRC_LSB = 0;
	localparam int CTC_CTRL_FAST_PLL_BIT = 2;
	localparam int CTC_CTRL_FREQ_LSB = 3;
	localparam int CTC_CTRL_PLL_EN_BIT = 5;
	// divider fields
	localparam int CTC_DIV_HS_LSB = 0;
	localparam int CTC_DIV_AUX_LSB = 8;
	// sleep field
	localparam int CTC_SLEEP_DEEP_BIT = 0;
	// status fields
	localparam int CTC_STAT_SRC_LSB = 0;
	localparam int CTC_STAT_FAST_PLL_BIT = 2;
	localparam int CTC_STAT_BUSY_BIT = 3;
	localparam int CTC_STAT_REF_OK_BIT = 4;
	localparam int CTC_STAT_HS_OVER_BIT = 5;
	localparam int CTC_STAT_AUX_OVER_BIT = 6;

	// ----------------------------------------
	// encodings and reset values
	// ----------------------------------------
	localparam logic [1:0] CTC_SRC_RING = 2'h0;
	localparam logic [1:0] CTC_SRC_TRIM = 2'h1;
	localparam logic [1:0] CTC_SRC_XTAL = 2'h2;
	localparam logic [1:0] CTC_SRC_EXT = 2'h3;
	localparam logic [1:0] CTC_FREQ_7M5 = 2'h3;
	localparam logic [1:0] CTC_RST_SRC = CTC_SRC_RING;
	localparam logic [1:0] CTC_RST_FREQ = CTC_FREQ_7M5;
	localparam logic [1:0] CTC_RST_HS_DIV = 2'h0;
	localparam logic [6:0] CTC_RST_AUX_M1 = 7'h00;
	localparam int CTC_NUM_PINS = 5;
	localparam int CTC_PIN_PLL = 4;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CTC_CLK_PERIOD_PS = 4000;
	localparam int CTC_WINDOW_NS = 4000;
	localparam logic [9:0] CTC_WINDOW_CYC = 10'(CTC_WINDOW_NS * 1000 / CTC_CLK_PERIOD_PS - 1);
	localparam int CTC_REF_MIN_MHZ = 1;
	localparam int CTC_REF_MAX_MHZ = 25;
	localparam int CTC_HS_MAX_MHZ = 50;
	localparam int CTC_AUX_MAX_MHZ = 100;
	localparam logic [9:0] CTC_REF_MIN_CNT = 10'(CTC_REF_MIN_MHZ * CTC_WINDOW_NS / 1000);
	localparam logic [9:0] CTC_REF_MAX_CNT = 10'(CTC_REF_MAX_MHZ * CTC_WINDOW_NS / 1000);
	localparam logic [9:0] CTC_HS_MAX_CNT = 10'(CTC_HS_MAX_MHZ * CTC_WINDOW_NS / 1000);
	localparam logic [9:0] CTC_AUX_MAX_CNT = 10'(CTC_AUX_MAX_MHZ * CTC_WINDOW_NS / 1000);

	typedef enum logic [2:0] {
		CTC_SW_RUN = 3'b001,
		CTC_SW_WAIT_LOW = 3'b010,
		CTC_SW_HOLD = 3'b100
	} ctc_sw_t;

endpackage : ctc_pkg

/* tb/ctc_src_model.sv */
module ctc_src_model (
	input wire logic [1:0] ring_osc_freq,
	input wire logic pll_enable,
	output logic ring_oscillator,
	output logic trim_rc_osc,
	output logic crystal_osc,
	output logic ext_clock_in,
	output logic pll_out_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// source oscillators
	// ----------------------------------------
	parameter real XTAL_HALF = 50.0;
	parameter real EXT_HALF = 25.0;
	parameter real PLL_HALF = 12.5;
	real rh;
	always_comb begin
		case (ring_osc_freq)
			2'b00: rh = 19.455;
			2'b01: rh = 36.232;
			2'b10: rh = 52.083;
			default: rh = 66.667;
		endcase
	end
	// no slow oscillator is offered to the tree
	initial begin
		ring_oscillator = 1'b0;
		forever #(rh) ring_oscillator = ~ring_oscillator;
	end
	initial begin
		trim_rc_osc = 1'b0;
		forever #125.0 trim_rc_osc = ~trim_rc_osc;
	end
	initial begin
		crystal_osc = 1'b0;
		forever #(XTAL_HALF) crystal_osc = ~crystal_osc;
	end
	initial begin
		ext_clock_in = 1'b0;
		forever #(EXT_HALF) ext_clock_in = ~ext_clock_in;
	end
	// pll stands low while disabled
	initial begin
		pll_out_clock = 1'b0;
		forever begin
			#(PLL_HALF);
			pll_out_clock = (pll_enable === 1'b1) ? ~pll_out_clock : 1'b0;
		end
	end
endmodule : ctc_src_model

/* tb/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ctc_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0] rf;
	logic pe, ro, tr, xo, eo, po;
	logic [9:0] mon;
	int fails = 0;
	int check_count = 0;
	int mhz[4] = '{257, 138, 96, 75};
	int srcm[4] = '{0, 40, 100, 200};
	logic [31:0] d;
	int n;
	ctc_clock_tree dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ring_oscillator(ro),
		.trim_rc_osc(tr), .crystal_osc(xo), .ext_clock_in(eo), .pll_out_clock(po), .ring_osc_freq(rf),
		.pll_enable(pe), .free_running_clock(mon[0]), .fast_clock(mon[1]), .power_mgr_clock(mon[2]),
		.high_speed_clock(mon[3]), .aux_clock(mon[4]), .adc_clock(mon[5]), .core_clock(mon[6]),
		.memory_clock(mon[7]), .serial_clock(mon[8]), .timer_clock(mon[9]));
	ctc_src_model src_u (.ring_osc_freq(rf), .pll_enable(pe), .ring_oscillator(ro), .trim_rc_osc(tr),
		.crystal_osc(xo), .ext_clock_in(eo), .pll_out_clock(po));
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// edge count over cyc cycles against rate in 0.1 MHz
	task cnt(input int i, input int cyc, input int m10);
		logic p;
		int e;
		e = m10 * cyc * 4 / 10000;
		n = 0;
		p = mon[i];
		repeat (cyc) begin
			@(posedge core_clk);
			#1;
			if (mon[i] === 1'b1 && p === 1'b0) n++;
			p = mon[i];
		end
		check_count++;
		if (n < e - 2 || n > e + 2) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, n, e);
		end
	endtask : cnt
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask : rd
	task settle;
		for (int k = 0; k < 300; k++) begin
			rd(CTC_ADDR_STATUS);
			if (d[CTC_STAT_BUSY_BIT] === 1'b0) break;
			if (k == 299) begin
				fails++;
				test_done();
			end
		end
		repeat (50) @(posedge core_clk);
	endtask : settle
	function automatic logic [31:0] ctl(logic [1:0] s, logic f, logic [1:0] r, logic e);
		return {26'h0, e, r, f, s};
	endfunction : ctl
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk(32'(rf), 32'h3);
		rd(CTC_ADDR_STATUS);
		chk(32'(d[1:0]), 32'(CTC_SRC_RING));
		rd(8'h10);
		chk(d, 32'h0);
		cnt(0, 1500, 75);
	endtask : t_reset
	task t_sources;
		for (int f = 0; f < 4; f++) begin
			wr(CTC_ADDR_CTRL, ctl(CTC_SRC_RING, 1'b0, 2'(f), 1'b0));
			settle();
			chk(32'(rf), 32'(f));
			cnt(0, 1500, mhz[f]);
			if (f == 0) begin
				repeat (1000) @(posedge core_clk);
				rd(CTC_ADDR_STATUS);
				chk(32'(d[CTC_STAT_REF_OK_BIT]), 32'h0);
			end
		end
		for (int s = 1; s < 4; s++) begin
			wr(CTC_ADDR_CTRL, ctl(2'(s), 1'b0, 2'h3, 1'b0));
			settle();
			chk(32'(d[1:0]), 32'(s));
			cnt(0, 1500, srcm[s]);
			cnt(1, 1500, srcm[s]);
		end
	endtask : t_sources
	task t_pll;
		wr(CTC_ADDR_CTRL, ctl(CTC_SRC_EXT, 1'b0, 2'h3, 1'b1));
		repeat (200) @(posedge core_clk);
		wr(CTC_ADDR_CTRL, ctl(CTC_SRC_EXT, 1'b1, 2'h3, 1'b1));
		settle();
		chk(32'(d[CTC_STAT_FAST_PLL_BIT]), 32'h1);
		cnt(1, 1500, 400);
		cnt(0, 1500, 200);
		rd(CTC_ADDR_STATUS);
		chk(32'(d[6:4]), 32'h1);
	endtask : t_pll
	task t_div;
		for (int c = 0; c < 4; c++) begin
			wr(CTC_ADDR_DIV, 32'(c));
			settle();
			cnt(3, 1500, 400 >> c);
		end
		wr(CTC_ADDR_DIV, 32'h0000_0200);
		settle();
		cnt(4, 1500, 133);
		cnt(3, 1500, 400);
		wr(CTC_ADDR_DIV, 32'h0000_7F00);
		repeat (1000) @(posedge core_clk);
		cnt(4, 20000, 3);
	endtask : t_div
	task t_sleep;
		wr(CTC_ADDR_DIV, 32'h0000_0101);
		repeat (1000) @(posedge core_clk);
		wr(CTC_ADDR_SLEEP, 32'h1);
		repeat (20) @(posedge core_clk);
		for (int i = 5; i < 10; i++) cnt(i, 1500, 0);
		cnt(2, 1500, 40);
		cnt(3, 1500, 200);
		wr(CTC_ADDR_SLEEP, 32'h0);
		repeat (20) @(posedge core_clk);
		cnt(5, 1500, 400);
		cnt(6, 1500, 200);
		cnt(7, 1500, 200);
		cnt(8, 1500, 200);
		cnt(9, 1500, 200);
		@(posedge core_clk);
		reset <= 1'b1;
	endtask : t_sleep
	initial begin
		#400us;
		fails++;
		test_done();
	end
	initial begin
		t_reset();
		t_sources();
		t_pll();
		t_div();
		t_sleep();
		t_reset();
		test_done();
	end
endmodule : testbench
